//--- design/stream3_attr_regs.sv
// Notes on behaviour
// - Attribute byte 0 holds sync-clock flag, format [2:1], range 3, colorimetry 4, depth [7:5].
// - Attribute byte 1 holds even-vertical-total in bit 0, stereo in [2:1], bits above reserved.
// - In asynchronous mode the computed M goes to the stream and the M register is untouched.
// - In asynchronous mode the computed N goes to the stream and the N register is untouched.
// - The transfer-unit size is 64 after reset.
// - Bit 0 of the transfer-unit size ignores writes, so the size stays even.
// - The pixel-width selector picks one, two or four pixels per beat with 1, 2 or 4.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "stream3_attr_map.svh"

module stream3_attr_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLK_I,               // Register clock, 50 MHz
    input  wire logic              RESETN_I,            // Synchronous reset, active low
    input  wire logic              PSEL_I,              // APB select
    input  wire logic              PENABLE_I,           // APB access phase
    input  wire logic              PWRITE_I,            // APB direction, high for write
    input  wire logic [ADDR_W-1:0] PADDR_I,             // APB byte address
    input  wire logic [31:0]       PWDATA_I,            // APB write data
    input  wire logic [3:0]        PSTRB_I,             // APB write byte lanes
    output logic                   PREADY_O,            // APB ready
    output logic      [31:0]       PRDATA_O,            // APB read data
    output logic                   PSLVERR_O,           // APB error, unmapped address
    input  wire logic [23:0]       AUTO_M_I,            // Computed M, asynchronous mode
    input  wire logic [23:0]       AUTO_N_I,            // Computed N, asynchronous mode
    output logic      [7:0]        ATTR_BYTE0_O,        // Attribute byte 0 to stream
    output logic      [7:0]        ATTR_BYTE1_O,        // Attribute byte 1 to stream
    output logic                   SYNC_CLOCK_O,        // Synchronous clocking mode
    output logic      [1:0]        COMPONENT_FORMAT_O,  // Component format
    output logic                   DYNAMIC_RANGE_O,     // Dynamic range
    output logic                   COLORIMETRY_O,       // Colorimetry
    output logic      [2:0]        BIT_DEPTH_O,         // Bit depth per component
    output logic                   VTOTAL_EVEN_O,       // Interlaced even vertical total
    output logic      [1:0]        STEREO_ATTR_O,       // Stereo video attribute
    output logic      [23:0]       INSERT_M_O,          // M value placed in stream
    output logic      [23:0]       INSERT_N_O,          // N value placed in stream
    output logic      [6:0]        TU_LENGTH_O,         // Transfer-unit size to framing
    output logic      [2:0]        PIXELS_PER_BEAT_O,   // Pixel-width selector
    output logic                   PIX_WIDTH_VALID_O    // Selector holds a defined code
);

    // Address space of the decoder is 12 bits at least; refused at elaboration
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be between 12 and 32");
    end

    // Register state
    logic [7:0]               attr0_q;
    logic [2:0]               attr1_q;
    logic [23:0]              m_q;
    logic [5:0]               tu_hi_q;
    logic [23:0]              n_q;
    logic [2:0]               pix_q;
    logic [31:0]              prdata_q;
    logic                     pix_valid_q;

    // Reset size kept at full width so only bits 6:1 are picked for storage
    localparam logic [6:0] TU_RST_VAL = `S3_TU_LENGTH_RST;

    // Bus decode
    logic [`S3_SEL_COUNT-1:0] sel;
    logic                     hit;
    logic                     wr_en;
    logic                     rd_setup;
    logic [31:0]              rd_word;
    logic [31:0]              m_d;
    logic [31:0]              n_d;
    logic [31:0]              low_d;

    stream3_reg_decode #(
        .ADDR_W (ADDR_W)
    ) u_decode (
        .paddr_i (PADDR_I),
        .sel_o   (sel),
        .hit_o   (hit)
    );

    // Zero wait states; writes land at the access edge
    assign PREADY_O  = 1'b1;
    assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

    // Merged words for every register
    assign low_d = stream3_attr_pkg::lane_merge(32'h00000000, PWDATA_I, PSTRB_I);
    assign m_d   = stream3_attr_pkg::lane_merge({8'h00, m_q}, PWDATA_I, PSTRB_I);
    assign n_d   = stream3_attr_pkg::lane_merge({8'h00, n_q}, PWDATA_I, PSTRB_I);

    // Attribute byte 0
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            attr0_q <= `S3_ATTR_BYTE0_RST;
        end else if (wr_en && sel[`S3_SEL_ATTR0] && PSTRB_I[0]) begin
            attr0_q <= low_d[7:0];
        end
    end

    // Attribute byte 1, reserved bits are not stored
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            attr1_q <= `S3_ATTR_BYTE1_RST;
        end else if (wr_en && sel[`S3_SEL_ATTR1] && PSTRB_I[0]) begin
            attr1_q <= low_d[2:0];
        end
    end

    // M holds only what software wrote; the computed value bypasses it
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            m_q <= `S3_CLK_REC_RST;
        end else if (wr_en && sel[`S3_SEL_M]) begin
            m_q <= m_d[23:0];
        end
    end

    // N holds only what software wrote
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            n_q <= `S3_CLK_REC_RST;
        end else if (wr_en && sel[`S3_SEL_N]) begin
            n_q <= n_d[23:0];
        end
    end

    // Only bits 6:1 of the transfer-unit size are stored
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            tu_hi_q <= TU_RST_VAL[6:1];
        end else if (wr_en && sel[`S3_SEL_TU] && PSTRB_I[0]) begin
            tu_hi_q <= low_d[6:1];
        end
    end

    // Range 32..64 is left to software; no clamping here
    assign TU_LENGTH_O = {tu_hi_q, 1'b0};

    // Pixel-width selector
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            pix_q <= `S3_PIX_PER_BEAT_RST;
        end else if (wr_en && sel[`S3_SEL_PIX] && PSTRB_I[0]) begin
            pix_q <= low_d[2:0];
        end
    end

    // Defined encodings flagged; reserved ones only drop the valid flag
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            pix_valid_q <= 1'b1;
        end else if (wr_en && sel[`S3_SEL_PIX] && PSTRB_I[0]) begin
            case (low_d[2:0])
                stream3_attr_pkg::PIX_ONE,
                stream3_attr_pkg::PIX_TWO,
                stream3_attr_pkg::PIX_FOUR: pix_valid_q <= 1'b1;
                default:                    pix_valid_q <= 1'b0;
            endcase
        end
    end

    assign PIXELS_PER_BEAT_O = pix_q;
    assign PIX_WIDTH_VALID_O = pix_valid_q;

    // Read mux; M and N return programmed contents in either mode
    always_comb begin
        rd_word = 32'h00000000;
        case (1'b1)
            sel[`S3_SEL_ATTR0]: rd_word = {24'h000000, attr0_q};
            sel[`S3_SEL_ATTR1]: rd_word = {29'h00000000, attr1_q};
            sel[`S3_SEL_M]:     rd_word = {8'h00, m_q};
            sel[`S3_SEL_TU]:    rd_word = {25'h0000000, TU_LENGTH_O};
            sel[`S3_SEL_N]:     rd_word = {8'h00, n_q};
            sel[`S3_SEL_PIX]:   rd_word = {29'h00000000, pix_q};
            default:            rd_word = 32'h00000000;
        endcase
    end

    // Read data captured in setup so it stands through the access phase
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= rd_word;
        end
    end

    assign PRDATA_O = prdata_q;

    // Field views of the attribute bytes
    assign ATTR_BYTE0_O       = attr0_q;
    assign SYNC_CLOCK_O       = attr0_q[`S3_A0_SYNC_BIT];
    assign COMPONENT_FORMAT_O = attr0_q[`S3_A0_FMT_LSB +: 2];
    assign DYNAMIC_RANGE_O    = attr0_q[`S3_A0_RANGE_BIT];
    assign COLORIMETRY_O      = attr0_q[`S3_A0_COLOR_BIT];
    assign BIT_DEPTH_O        = attr0_q[`S3_A0_DEPTH_LSB +: 3];
    assign ATTR_BYTE1_O       = {5'h00, attr1_q};
    assign VTOTAL_EVEN_O      = attr1_q[`S3_A1_VT_EVEN_BIT];
    assign STEREO_ATTR_O      = attr1_q[`S3_A1_STEREO_LSB +: 2];

    // Stream values picked by clocking mode, one cycle of latency
    stream3_mn_select u_mn_select (
        .clk_i      (CLK_I),
        .resetn_i   (RESETN_I),
        .sync_clk_i (attr0_q[`S3_A0_SYNC_BIT]),
        .prog_m_i   (m_q),
        .prog_n_i   (n_q),
        .auto_m_i   (AUTO_M_I),
        .auto_n_i   (AUTO_N_I),
        .ins_m_o    (INSERT_M_O),
        .ins_n_o    (INSERT_N_O)
    );

    // Checks on the register behaviour
    sequence s_write(logic target);
        PSEL_I && PENABLE_I && PWRITE_I && target;
    endsequence

    sequence s_read_access(logic target);
        PSEL_I && PENABLE_I && !PWRITE_I && target;
    endsequence

    a_attr0_fields: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_write(sel[`S3_SEL_ATTR0] && PSTRB_I[0]) |=>
            (SYNC_CLOCK_O == $past(PWDATA_I[0])) &&
            (COMPONENT_FORMAT_O == $past(PWDATA_I[2:1])) &&
            (BIT_DEPTH_O == $past(PWDATA_I[7:5])))
        else $error("attribute byte 0 fields do not follow the write");

    a_attr1_reserved: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(sel[`S3_SEL_ATTR1]) |->
            (PRDATA_O[31:3] == 29'h00000000) && (PRDATA_O[2:0] == {STEREO_ATTR_O, VTOTAL_EVEN_O}))
        else $error("attribute byte 1 read shows reserved bits or wrong fields");

    // Two asynchronous cycles, the first with no software write to the register
    sequence s_async_quiet(logic wr_target);
        !SYNC_CLOCK_O && !(PSEL_I && PENABLE_I && PWRITE_I && wr_target) ##1 !SYNC_CLOCK_O;
    endsequence

    a_m_kept_async: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_async_quiet(sel[`S3_SEL_M]) |->
            $stable(m_q) && (INSERT_M_O == $past(AUTO_M_I)))
        else $error("M register changed or computed M not inserted");

    a_n_insert_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        SYNC_CLOCK_O |=> INSERT_N_O == $past(n_q))
        else $error("programmed N not inserted in synchronous mode");

    a_n_no_writeback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !(PSEL_I && PENABLE_I && PWRITE_I && sel[`S3_SEL_N]) |=> n_q == $past(n_q))
        else $error("N register changed without a software write");

    a_tu_after_reset: assert property (@(posedge CLK_I)
        !RESETN_I |=> TU_LENGTH_O == 7'h40)
        else $error("transfer-unit size is not 64 after reset");

    a_tu_write_even: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_write(sel[`S3_SEL_TU] && PSTRB_I[0]) |=>
            TU_LENGTH_O == {$past(PWDATA_I[6:1]), 1'b0})
        else $error("transfer-unit size write not taken with bit 0 forced low");

    a_pix_width_set: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_write(sel[`S3_SEL_PIX] && PSTRB_I[0]) |=>
            PIXELS_PER_BEAT_O == $past(PWDATA_I[2:0]))
        else $error("pixel-width selector does not follow the write");

    a_pix_reserved: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        ##1 PIX_WIDTH_VALID_O == ((PIXELS_PER_BEAT_O == 3'h1) ||
                                  (PIXELS_PER_BEAT_O == 3'h2) ||
                                  (PIXELS_PER_BEAT_O == 3'h4)))
        else $error("pixel-width valid flag disagrees with the selector");

    a_err_unmapped: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (PSEL_I && PENABLE_I) |-> (PSLVERR_O == !hit) && PREADY_O)
        else $error("error response does not match the address decode");

    a_err_idle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !PSEL_I |-> !PSLVERR_O)
        else $error("error response raised with no transfer");

    a_attr1_fields: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_write(sel[`S3_SEL_ATTR1] && PSTRB_I[0]) |=>
            (VTOTAL_EVEN_O == $past(PWDATA_I[0])) &&
            (STEREO_ATTR_O == $past(PWDATA_I[2:1])) && (ATTR_BYTE1_O[7:3] == 5'h00))
        else $error("attribute byte 1 fields do not follow the write");

    // Programmed values reach the stream only in synchronous mode
    a_m_insert_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        SYNC_CLOCK_O |=> INSERT_M_O == $past(m_q))
        else $error("programmed M not inserted in synchronous mode");

    a_m_no_writeback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !(PSEL_I && PENABLE_I && PWRITE_I && sel[`S3_SEL_M]) |=> m_q == $past(m_q))
        else $error("M register changed without a software write");

    a_n_kept_async: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_async_quiet(sel[`S3_SEL_N]) |->
            $stable(n_q) && (INSERT_N_O == $past(AUTO_N_I)))
        else $error("N register changed or computed N not inserted");

    // A write that leaves lane 0 unset must keep the low byte of M
    a_m_lane_keep: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_write(sel[`S3_SEL_M] && !PSTRB_I[0]) |=> m_q[7:0] == $past(m_q[7:0]))
        else $error("M low byte changed by a write without its lane");

    // Read-back paths; a stale word here would hide a wrong register
    a_m_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(sel[`S3_SEL_M]) |-> PRDATA_O == {8'h00, m_q})
        else $error("M read does not return the programmed value");

    a_n_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(sel[`S3_SEL_N]) |-> PRDATA_O == {8'h00, n_q})
        else $error("N read does not return the programmed value");

    a_tu_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(sel[`S3_SEL_TU]) |-> PRDATA_O == {25'h0000000, TU_LENGTH_O})
        else $error("transfer-unit size read does not match the output");

    a_pix_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(sel[`S3_SEL_PIX]) |-> PRDATA_O == {29'h00000000, PIXELS_PER_BEAT_O})
        else $error("pixel-width read does not match the selector");

    a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_access(!hit) |-> PRDATA_O == 32'h00000000)
        else $error("unmapped read returns nonzero data");

    // Reset values seen on the outputs one edge after reset
    a_pix_after_reset: assert property (@(posedge CLK_I)
        !RESETN_I |=> (PIXELS_PER_BEAT_O == 3'h1) && PIX_WIDTH_VALID_O)
        else $error("pixel-width selector is not single after reset");

    a_attr_after_reset: assert property (@(posedge CLK_I)
        !RESETN_I |=> (ATTR_BYTE0_O == 8'h00) && (ATTR_BYTE1_O == 8'h00))
        else $error("attribute bytes are not clear after reset");

    a_ins_after_reset: assert property (@(posedge CLK_I)
        !RESETN_I |=> (INSERT_M_O == 24'h000000) && (INSERT_N_O == 24'h000000))
        else $error("inserted M or N not clear after reset");

endmodule // stream3_attr_regs

//--- design/stream3_mn_select.sv
`timescale 1ns/10ps

module stream3_mn_select (
    input  wire logic        clk_i,      // Register clock
    input  wire logic        resetn_i,   // Synchronous reset, active low
    input  wire logic        sync_clk_i, // Synchronous clocking mode
    input  wire logic [23:0] prog_m_i,   // Programmed M
    input  wire logic [23:0] prog_n_i,   // Programmed N
    input  wire logic [23:0] auto_m_i,   // Computed M
    input  wire logic [23:0] auto_n_i,   // Computed N
    output logic      [23:0] ins_m_o,    // M inserted into main stream
    output logic      [23:0] ins_n_o     // N inserted into main stream
);

    // Computed values go only to the stream, never to the programmed copy
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ins_m_o <= 24'h000000;
            ins_n_o <= 24'h000000;
        end else begin
            ins_m_o <= sync_clk_i ? prog_m_i : auto_m_i;
            ins_n_o <= sync_clk_i ? prog_n_i : auto_n_i;
        end
    end

endmodule // stream3_mn_select

//--- design/stream3_reg_decode.sv
`timescale 1ns/10ps
`include "stream3_attr_map.svh"

module stream3_reg_decode #(
    parameter int ADDR_W = 12
) (
    input  wire logic [ADDR_W-1:0]         paddr_i, // Byte address
    output logic      [`S3_SEL_COUNT-1:0]  sel_o,   // One-hot register select
    output logic                           hit_o    // Address maps a register
);

    // Offsets fit in 12 bits; upper address bits must be zero
    always_comb begin
        sel_o = '0;
        if ((paddr_i >> 12) == '0) begin
            case (paddr_i[11:0])
                `S3_ATTR_BYTE0_OFF:   sel_o[`S3_SEL_ATTR0] = 1'b1;
                `S3_ATTR_BYTE1_OFF:   sel_o[`S3_SEL_ATTR1] = 1'b1;
                `S3_CLK_REC_M_OFF:    sel_o[`S3_SEL_M]     = 1'b1;
                `S3_TU_LENGTH_OFF:    sel_o[`S3_SEL_TU]    = 1'b1;
                `S3_CLK_REC_N_OFF:    sel_o[`S3_SEL_N]     = 1'b1;
                `S3_PIX_PER_BEAT_OFF: sel_o[`S3_SEL_PIX]   = 1'b1;
                default:              sel_o = '0;
            endcase
        end
    end

    assign hit_o = |sel_o;

endmodule // stream3_reg_decode

//--- shared/stream3_attr_map.svh
`ifndef STREAM3_ATTR_MAP_SVH
`define STREAM3_ATTR_MAP_SVH

// Register byte offsets, one aligned 32-bit word each
`define S3_ATTR_BYTE0_OFF        12'h574
`define S3_ATTR_BYTE1_OFF        12'h578
`define S3_CLK_REC_M_OFF         12'h57C
`define S3_TU_LENGTH_OFF         12'h580
`define S3_CLK_REC_N_OFF         12'h584
`define S3_PIX_PER_BEAT_OFF      12'h588

// One-hot select positions
`define S3_SEL_ATTR0             0
`define S3_SEL_ATTR1             1
`define S3_SEL_M                 2
`define S3_SEL_TU                3
`define S3_SEL_N                 4
`define S3_SEL_PIX               5
`define S3_SEL_COUNT             6

// Attribute byte 0 fields
`define S3_A0_SYNC_BIT           0
`define S3_A0_FMT_LSB            1
`define S3_A0_RANGE_BIT          3
`define S3_A0_COLOR_BIT          4
`define S3_A0_DEPTH_LSB          5
// Attribute byte 1 fields, bits 7:3 reserved
`define S3_A1_VT_EVEN_BIT        0
`define S3_A1_STEREO_LSB         1

// Reset values
`define S3_ATTR_BYTE0_RST        8'h00
`define S3_ATTR_BYTE1_RST        3'h0
`define S3_CLK_REC_RST           24'h000000
`define S3_TU_LENGTH_RST         7'h40
`define S3_PIX_PER_BEAT_RST      3'h1

`endif

//--- shared/stream3_attr_pkg.sv
package stream3_attr_pkg;

    // Pixel-width selector encodings; others are reserved
    typedef enum logic [2:0] {
        PIX_ONE  = 3'h1,
        PIX_TWO  = 3'h2,
        PIX_FOUR = 3'h4
    } pix_width_t;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

//--- tb/tb_mst_stream3_attribute_regs.sv
`timescale 1ns/10ps
`include "stream3_attr_map.svh"

module tb_mst_stream3_attribute_regs;
    // Generous ceiling; the full sequence needs well under 1000 cycles
    localparam int TIMEOUT_CYCLES = 4000;

    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [23:0] auto_m;
    logic [23:0] auto_n;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  attr0;
    logic [7:0]  attr1;
    logic        sync_clk;
    logic [1:0]  comp_fmt;
    logic        dyn_range;
    logic        colorimetry;
    logic [2:0]  bit_depth;
    logic        vt_even;
    logic [1:0]  stereo;
    logic [23:0] ins_m;
    logic [23:0] ins_n;
    logic [6:0]  tu_len;
    logic [2:0]  pix;
    logic        pix_ok;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          checks_done;
    int          cycles;

    stream3_attr_regs #(.ADDR_W(12)) i_dut (
        .CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
        .AUTO_M_I(auto_m), .AUTO_N_I(auto_n), .ATTR_BYTE0_O(attr0), .ATTR_BYTE1_O(attr1),
        .SYNC_CLOCK_O(sync_clk), .COMPONENT_FORMAT_O(comp_fmt), .DYNAMIC_RANGE_O(dyn_range),
        .COLORIMETRY_O(colorimetry), .BIT_DEPTH_O(bit_depth), .VTOTAL_EVEN_O(vt_even),
        .STEREO_ATTR_O(stereo), .INSERT_M_O(ins_m), .INSERT_N_O(ins_n),
        .TU_LENGTH_O(tu_len), .PIXELS_PER_BEAT_O(pix), .PIX_WIDTH_VALID_O(pix_ok)
    );

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard: a stuck handshake still reaches the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Let the edge's updates land before looking at outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    // Reset contents of every register through the bus, and of the transfer-unit and pixel-width outputs
    task automatic t_reset_values();
        logic [11:0] adr [6];
        logic [31:0] exp [6];
        adr = '{`S3_ATTR_BYTE0_OFF, `S3_ATTR_BYTE1_OFF, `S3_CLK_REC_M_OFF,
                `S3_TU_LENGTH_OFF, `S3_CLK_REC_N_OFF, `S3_PIX_PER_BEAT_OFF};
        exp = '{32'(`S3_ATTR_BYTE0_RST), 32'(`S3_ATTR_BYTE1_RST), 32'(`S3_CLK_REC_RST),
                32'h0000_0040, 32'(`S3_CLK_REC_RST), 32'(`S3_PIX_PER_BEAT_RST)};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, adr[i], 32'h0, 4'h0);
            chk(rd, exp[i]);
        end
        chk({25'h0, tu_len}, 32'h0000_0040);
        chk({29'h0, pix}, 32'h0000_0001);
    endtask

    // Every field of byte 0 lands on its own output
    task automatic t_attr0();
        logic [7:0] v [6];
        v = '{8'h01, 8'h06, 8'h08, 8'h10, 8'hE0, 8'hB5};
        foreach (v[i]) begin
            wr32(`S3_ATTR_BYTE0_OFF, {24'hFFFFFF, v[i]});
            settle(1);
            chk({24'h0, bit_depth, colorimetry, dyn_range, comp_fmt, sync_clk}, 32'(v[i]));
            chk({24'h0, attr0}, 32'(v[i]));
            apb(1'b0, `S3_ATTR_BYTE0_OFF, 32'h0, 4'h0);
            chk(rd, 32'(v[i]));
        end
    endtask

    // Reserved upper bits of byte 1 never stick
    task automatic t_attr1();
        wr32(`S3_ATTR_BYTE1_OFF, 32'hFFFF_FFFF);
        settle(1);
        chk({29'h0, stereo, vt_even}, 32'h7);
        chk({24'h0, attr1}, 32'h7);
        apb(1'b0, `S3_ATTR_BYTE1_OFF, 32'h0, 4'h0);
        chk(rd, 32'h7);
        wr32(`S3_ATTR_BYTE1_OFF, 32'h0000_0004);
        settle(1);
        chk({29'h0, stereo, vt_even}, 32'h4);
    endtask

    // Programmed M/N in synchronous mode, computed ones otherwise
    task automatic t_clock_recovery();
        @(posedge clk);
        auto_m <= 24'h111111;
        auto_n <= 24'h222222;
        wr32(`S3_ATTR_BYTE0_OFF, 32'h1);
        wr32(`S3_CLK_REC_M_OFF, 32'h00AB_CDEF);
        wr32(`S3_CLK_REC_N_OFF, 32'h0012_3456);
        apb(1'b1, `S3_CLK_REC_M_OFF, 32'h00FF_0000, 4'b0100);
        settle(2);
        chk({8'h0, ins_m}, 32'h00FF_CDEF);
        chk({8'h0, ins_n}, 32'h0012_3456);
        wr32(`S3_ATTR_BYTE0_OFF, 32'h0);
        settle(2);
        chk({8'h0, ins_m}, 32'h0011_1111);
        chk({8'h0, ins_n}, 32'h0022_2222);
        @(posedge clk);
        auto_m <= 24'h333333;
        auto_n <= 24'h444444;
        settle(2);
        chk({8'h0, ins_m}, 32'h0033_3333);
        chk({8'h0, ins_n}, 32'h0044_4444);
        apb(1'b0, `S3_CLK_REC_M_OFF, 32'h0, 4'h0);
        chk(rd, 32'h00FF_CDEF);
        apb(1'b0, `S3_CLK_REC_N_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0012_3456);
    endtask

    // Odd sizes lose bit 0; the range edges are taken as written
    task automatic t_tu_length();
        logic [6:0] v [4];
        v = '{7'h21, 7'h3F, 7'h40, 7'h20};
        foreach (v[i]) begin
            wr32(`S3_TU_LENGTH_OFF, {25'h0, v[i]});
            settle(1);
            chk({25'h0, tu_len}, {25'h0, v[i] & 7'h7E});
            apb(1'b0, `S3_TU_LENGTH_OFF, 32'h0, 4'h0);
            chk(rd, {25'h0, v[i] & 7'h7E});
        end
    endtask

    // Defined widths and reserved codes of the pixel selector
    task automatic t_pixels();
        logic [2:0] v [6];
        v = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h7};
        foreach (v[i]) begin
            wr32(`S3_PIX_PER_BEAT_OFF, {29'h0, v[i]});
            settle(1);
            chk({29'h0, pix}, {29'h0, v[i]});
            chk({31'h0, pix_ok}, {31'h0, (v[i] == 3'h1 || v[i] == 3'h2 || v[i] == 3'h4)});
        end
        wr32(`S3_PIX_PER_BEAT_OFF, 32'h0000_0004);
        settle(1);
        chk({28'h0, pix, pix_ok}, 32'h0000_0009);
    endtask

    // Addresses outside the group are refused and leave neighbours intact
    task automatic t_unmapped();
        wr32(12'h58C, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h58C, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h570, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b0, `S3_TU_LENGTH_OFF, 32'h0, 4'h0);
        chk(rd, 32'h0000_0020);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic tally_and_finish();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence, with a second reset in mid-run
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        auto_m = 24'h0;
        auto_n = 24'h0;
        fail_count = 0;
        checks_done = 0;
        cycles = 0;
        do_reset();
        t_reset_values();
        t_attr0();
        t_attr1();
        t_clock_recovery();
        t_tu_length();
        t_pixels();
        t_unmapped();
        do_reset();
        t_reset_values();
        tally_and_finish();
    end
endmodule // tb_mst_stream3_attribute_regs
